/* File: verilog/flash_array_erase_protect_ctrl.sv */
// flash_array_erase_protect_ctrl: control register, protection and
// program/erase sequence checking of the flash array
// assumes a classic Wishbone master on the same clock
//
// Contract
// RULE1: erased cell reads one, programmed zero
// RULE2: erase unit is one 128-byte page
// RULE3: program one 64-byte row at a time
// RULE4: user array holds 32,256 bytes plus extras
// RULE5: high voltage set only after proper sequence
// RULE6: high voltage bit drives charge pump
// RULE7: mass bit picks whole-array or page erase
// RULE8: erase and program never both set
// RULE9: protect byte maps to address bits 14:7
// RULE10: protect to top; all ones protects nothing
// RULE11: one below all ones protects 256 bytes
// RULE12: refuse high voltage on protected target
// RULE13: all-zero protect byte locks whole array
// RULE14: master reads protect byte before high voltage
// RULE15: protect byte changes only by programming
// RULE16: erasing vector page also erases protect bytes
// RULE17: master follows the mass erase order
// RULE18: no erase if latched address protected
// RULE19: master follows the page erase order
// RULE20: master avoids array accesses between steps
// RULE21: master runs code elsewhere, interrupts off
// RULE22: reset clears control bits, pump off
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module flash_array_erase_protect_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter bit INIT_BLANK = 1'b1
) (
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [17:2] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // array analog side
  output logic             PUMP_ON_O,
  output logic             ARRAY_BUSY_O
);

  typedef struct packed {
    seq_t        seq;
    logic        high_voltage_enable;
    logic        mass;
    logic        erase;
    logic        program_select;
    logic        refused;
    logic        lat_prot;
    logic [15:0] latch_addr;
    logic [11:0] setup_cnt;
    logic        ack;
    logic [7:0]  dat;
  } ctrl_state_t;

  ctrl_state_t r_reg;
  ctrl_state_t r_next;
  flash_array_if arr ();

  // ==========================================================
  // protection decode
  function automatic logic [15:0] prot_start(input logic [7:0] b);
    return {1'b1, b, 7'h00}; // [RULE9] [RULE11]
  endfunction

  function automatic logic is_protected(input logic [15:0] a, input logic [7:0] b);
    return (b != PROT_NONE) && (a >= prot_start(b)); // [RULE10] [RULE13]
  endfunction

  // ==========================================================
  // address decode
  logic [15:0] addr;
  logic        req;
  logic        is_ctrl;
  logic        is_stat;
  logic        exists;
  logic        stall;
  logic        wr_ok;
  logic [7:0]  wd;
  logic        same_row;
  logic        sel_any;

  assign addr     = WB_ADR_I;
  assign req      = WB_CYC_I && WB_STB_I && !r_reg.ack;
  assign is_ctrl  = addr == CTRL_IDX;
  assign is_stat  = addr == STAT_IDX;
  // array cells: user area plus the protect/vector page
  assign exists   = addr[15] && (addr < USER_TOP || addr >= PROT_IDX)
                    && !is_ctrl && !is_stat; // [RULE4]
  assign stall    = req && exists && arr.busy;
  assign wr_ok    = req && !stall && WB_WE_I && WB_SEL_I[0];
  assign wd       = WB_DAT_I[7:0];
  assign same_row = addr[15:6] == r_reg.latch_addr[15:6]; // [RULE3]

  // ==========================================================
  // sequencer and register file
  always_comb begin
    r_next          = r_reg;
    sel_any         = 1'b0;
    arr.rd_addr     = addr[ARRAY_AW-1:0];
    arr.wr_en       = 1'b0;
    arr.wr_addr     = addr[ARRAY_AW-1:0];
    arr.wr_data     = wd;
    arr.sweep_start = 1'b0;
    arr.sweep_base  = '0;
    arr.sweep_count = '0;

    // ack drops the cycle after it was given
    if (r_reg.ack) begin
      r_next.ack = 1'b0;
    end

    // setup time runs from the address latch
    if (r_reg.seq == SEQ_LATCHED && r_reg.setup_cnt != 12'h000) begin
      r_next.setup_cnt = r_reg.setup_cnt - 12'h001;
    end

    if (req && !stall) begin
      r_next.ack = 1'b1;
      r_next.dat = 8'h00;
      if (is_ctrl) begin
        r_next.dat = {4'h0, r_reg.high_voltage_enable, r_reg.mass, r_reg.erase, r_reg.program_select};
      end else if (is_stat) begin
        r_next.dat = {5'h00, r_reg.lat_prot, arr.busy, r_reg.refused};
      end else if (exists) begin
        r_next.dat = arr.rd_data;
      end

      // reading the protect byte arms the address latch
      if (!WB_WE_I && addr == PROT_IDX && r_reg.seq == SEQ_SELECTED) begin
        r_next.seq = SEQ_PROT_READ; // [RULE14]
      end

      // array writes: address latch or row programming
      if (wr_ok && exists) begin
        if (r_reg.seq == SEQ_PROT_READ) begin
          r_next.seq        = SEQ_LATCHED;
          r_next.latch_addr = addr;
          r_next.lat_prot   = is_protected(addr, arr.prot_byte); // [RULE18]
          r_next.setup_cnt  = 12'(SETUP_CYC);
        end else if (r_reg.seq == SEQ_HIGH_VOLT && r_reg.program_select && same_row
                     && !is_protected(addr, arr.prot_byte)) begin
          arr.wr_en = 1'b1; // [RULE3] [RULE15]
        end
      end

      // control register write
      if (wr_ok && is_ctrl) begin
        r_next.mass = wd[MASS_BIT]; // [RULE7]
        if (!(wd[PGM_BIT] && wd[ERASE_BIT])) begin
          r_next.program_select   = wd[PGM_BIT]; // [RULE8]
          r_next.erase = wd[ERASE_BIT]; // [RULE8]
        end
        sel_any = r_next.program_select || r_next.erase;
        if (!wd[HIGH_VOLTAGE_ENABLE_BIT]) begin
          r_next.high_voltage_enable = 1'b0; // [RULE6]
          r_next.seq  = sel_any ? SEQ_SELECTED : SEQ_IDLE;
        end else if (!r_reg.high_voltage_enable) begin
          if (sel_any && r_reg.seq == SEQ_LATCHED && r_reg.setup_cnt == 12'h000
              && !r_reg.lat_prot) begin
            r_next.high_voltage_enable = 1'b1; // [RULE5] [RULE12]
            r_next.seq  = SEQ_HIGH_VOLT;
            if (r_next.erase) begin
              arr.sweep_start = 1'b1; // [RULE18]
              if (r_next.mass) begin
                // whole array below the protected start
                arr.sweep_base  = '0; // [RULE7]
                arr.sweep_count = (arr.prot_byte == PROT_NONE) ? ARRAY_DEPTH
                                  : {1'b0, arr.prot_byte, 7'h00}; // [RULE16]
              end else begin
                arr.sweep_base  = {r_reg.latch_addr[14:7], 7'h00}; // [RULE2] [RULE16]
                arr.sweep_count = 16'(PAGE_BYTES); // [RULE2]
              end
            end
          end else begin
            r_next.high_voltage_enable    = 1'b0;
            r_next.refused = 1'b1; // [RULE12]
          end
        end
        if (wd[HIGH_VOLTAGE_ENABLE_BIT] && r_reg.high_voltage_enable && !sel_any) begin
          r_next.seq = SEQ_HOLD;
        end else if (!wd[HIGH_VOLTAGE_ENABLE_BIT] || !r_reg.high_voltage_enable) begin
          if (r_next.seq == SEQ_IDLE && sel_any) begin
            r_next.seq = SEQ_SELECTED;
          end else if (!sel_any) begin
            r_next.seq = SEQ_IDLE;
          end
        end
      end

      // status write one clears refused; a new refusal wins
      if (wr_ok && is_stat && wd[REFUSED_BIT] && !(r_next.refused && !r_reg.refused)) begin
        r_next.refused = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r_reg <= '{seq: SEQ_IDLE, high_voltage_enable: CTRL_RESET[HIGH_VOLTAGE_ENABLE_BIT], mass: CTRL_RESET[MASS_BIT],
                 erase: CTRL_RESET[ERASE_BIT], program_select: CTRL_RESET[PGM_BIT], // [RULE22]
                 refused: 1'b0, lat_prot: 1'b0, latch_addr: 16'h0000,
                 setup_cnt: 12'h000, ack: 1'b0, dat: 8'h00};
    end else begin
      r_reg <= r_next;
    end
  end

  // cell array
  flash_cell_array #(
    .INIT_BLANK (INIT_BLANK)
  ) u_cells (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .arr     (arr.cells)
  );

  // outputs
  assign WB_ACK_O     = r_reg.ack;
  assign WB_DAT_O     = {24'h000000, r_reg.dat};
  assign PUMP_ON_O    = r_reg.high_voltage_enable; // [RULE6]
  assign ARRAY_BUSY_O = arr.busy;

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_bus_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !stall;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  sequence s_hv_rise;
    !r_reg.high_voltage_enable ##1 r_reg.high_voltage_enable;
  endsequence

  a_ack_one_cycle: assert property (s_bus_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  a_hv_after_latch: assert property (s_hv_rise |-> $past(r_reg.seq) == SEQ_LATCHED
                                     && $past(r_reg.setup_cnt) == 12'h000) // [RULE5]
    else $error("high voltage set outside sequence");
  a_hv_needs_select: assert property (s_hv_rise |-> r_reg.program_select || r_reg.erase) // [RULE5]
    else $error("high voltage without select");
  // pump runs only while a sequence holds high voltage
  a_pump_tracks_hv: assert property (PUMP_ON_O |-> r_reg.seq == SEQ_HIGH_VOLT // [RULE6]
                                     || r_reg.seq == SEQ_HOLD)
    else $error("pump on outside high voltage phase");
  a_select_interlock: assert property (!(r_reg.program_select && r_reg.erase)) // [RULE8]
    else $error("program and erase both set");
  a_hv_refuse_prot: assert property (s_hv_rise |-> !$past(r_reg.lat_prot)) // [RULE12]
    else $error("high voltage on protected target");
  a_page_erase_len: assert property (arr.sweep_start && !r_next.mass
                                     |-> arr.sweep_count == 16'(PAGE_BYTES)) // [RULE2]
    else $error("page erase length wrong");
  a_mass_stops_prot: assert property (arr.sweep_start && r_next.mass
                                      && arr.prot_byte != PROT_NONE
                                      |-> {1'b1, arr.sweep_count[14:0]}
                                      == prot_start(arr.prot_byte)) // [RULE10]
    else $error("mass erase enters protected range");
  a_program_in_row: assert property (arr.wr_en |-> same_row
                                     && !is_protected(addr, arr.prot_byte)) // [RULE3]
    else $error("program outside latched row");
  a_prot_top_page: assert property (is_protected(16'hFF00, arr.prot_byte)
                                    == (arr.prot_byte != PROT_NONE)) // [RULE11]
    else $error("top pages not protected");

  // control write that asks for high voltage
  sequence s_hv_request;
    wr_ok && is_ctrl && wd[HIGH_VOLTAGE_ENABLE_BIT] && !r_reg.high_voltage_enable;
  endsequence
  // a request on a protected latch is refused and flagged
  a_refuse_flags: assert property (s_hv_request ##0 r_reg.lat_prot // [RULE12]
                                   |=> !r_reg.high_voltage_enable && r_reg.refused)
    else $error("protected request not refused");
  // a request with neither select set is refused
  a_refuse_nosel: assert property (s_hv_request ##0 !sel_any // [RULE5]
                                   |=> !r_reg.high_voltage_enable && r_reg.refused)
    else $error("high voltage granted without select");
  // erase sweeps never start on a protected latch
  a_no_sweep_prot: assert property (arr.sweep_start |-> !r_reg.lat_prot // [RULE18]
                                    && r_next.erase && !r_next.program_select)
    else $error("erase sweep on protected target");
  // page sweep covers the latched page only
  a_page_in_target: assert property (arr.sweep_start && !r_next.mass // [RULE2]
                                     |-> arr.sweep_base[14:7] == r_reg.latch_addr[14:7]
                                     && arr.sweep_base[6:0] == 7'h00)
    else $error("page erase off target");
  // cells change under program only with high voltage on
  a_write_needs_hv: assert property (arr.wr_en |-> r_reg.high_voltage_enable && r_reg.program_select) // [RULE15]
    else $error("cell written outside programming");
  // reset leaves every control bit clear
  a_reset_clears: assert property ($rose(RST_N_I) |-> !r_reg.high_voltage_enable && !r_reg.mass // [RULE22]
                                   && !r_reg.erase && !r_reg.program_select)
    else $error("control bits set after reset");

endmodule // flash_array_erase_protect_ctrl

/* File: verilog/flash_ctrl_pkg.sv */
// flash_ctrl_pkg: constants and types of the flash array controller
// assumes a 250 MHz bus clock and a 16-bit word index on the bus
package flash_ctrl_pkg;

  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [15:0] ARRAY_BASE_IDX  = 16'h8000;
  localparam logic [15:0] PROT_IDX        = 16'hFF80;
  localparam logic [15:0] PROT2_IDX       = 16'hFF81;
  localparam logic [15:0] CTRL_IDX        = 16'hFF88;
  localparam logic [15:0] STAT_IDX        = 16'hFF89;

  // ==========================================================
  // control and status fields
  localparam int PGM_BIT     = 0;
  localparam int ERASE_BIT   = 1;
  localparam int MASS_BIT    = 2;
  localparam int HIGH_VOLTAGE_ENABLE_BIT    = 3;
  localparam int REFUSED_BIT = 0;
  localparam int BUSY_BIT    = 1;
  localparam int LATPROT_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // array geometry
  localparam int          ARRAY_AW   = 15;
  localparam int          ROW_BYTES  = 64;
  localparam int          PAGE_BYTES = 128;
  localparam int          USER_BYTES = 32256;
  localparam logic [7:0]  ERASED     = 8'hFF;
  localparam logic [7:0]  PROT_NONE  = 8'hFF;
  localparam logic [15:0] USER_TOP   = 16'(32'h8000 + USER_BYTES);
  localparam logic [15:0] ARRAY_DEPTH = 16'h8000;

  // ==========================================================
  // timing
  localparam int          CLK_MHZ   = 250;
  localparam int          SETUP_NS  = 10000;
  localparam int          SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // sequence states
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_SELECTED, SEQ_PROT_READ, SEQ_LATCHED, SEQ_HIGH_VOLT, SEQ_HOLD
  } seq_t;

endpackage

/* File: verilog/flash_array_if.sv */
// flash_array_if: link between the sequencer and the cell array
// assumes both ends on the same clock
`timescale 1ns/1ps
interface flash_array_if;
  import flash_ctrl_pkg::*;
  logic [ARRAY_AW-1:0] rd_addr;
  logic [7:0]          rd_data;
  logic [7:0]          prot_byte;
  logic                wr_en;
  logic [ARRAY_AW-1:0] wr_addr;
  logic [7:0]          wr_data;
  logic                sweep_start;
  logic [ARRAY_AW-1:0] sweep_base;
  logic [ARRAY_AW:0]   sweep_count;
  logic                busy;
  modport ctrl  (output rd_addr, wr_en, wr_addr, wr_data, sweep_start, sweep_base,
                 sweep_count, input rd_data, prot_byte, busy);
  modport cells (input rd_addr, wr_en, wr_addr, wr_data, sweep_start, sweep_base,
                 sweep_count, output rd_data, prot_byte, busy);
endinterface // flash_array_if

/* File: verilog/flash_cell_array.sv */
// flash_cell_array: byte cells with erase sweep and bit-clearing program
// assumes the sequencer only starts a sweep when not busy
`timescale 1ns/1ps
module flash_cell_array
  import flash_ctrl_pkg::*;
#(
  parameter bit INIT_BLANK = 1'b1
) (
  // clock and reset
  input  wire logic    clk_i,
  input  wire logic    rst_n_i,
  // sequencer side
  flash_array_if.cells arr
);

  typedef struct packed {
    logic                init_pend;
    logic                busy;
    logic [ARRAY_AW-1:0] ptr;
    logic [ARRAY_AW:0]   remain;
  } cell_state_t;

  cell_state_t r_reg;
  cell_state_t r_next;
  logic [7:0]  mem [0:(1<<ARRAY_AW)-1];

  // ==========================================================
  // sweep engine
  always_comb begin
    r_next = r_reg;
    if (r_reg.init_pend) begin
      r_next.init_pend = 1'b0;
      r_next.busy      = 1'b1;
      r_next.ptr       = '0;
      r_next.remain    = ARRAY_DEPTH;
    end else if (arr.sweep_start && !r_reg.busy) begin
      r_next.busy   = 1'b1;
      r_next.ptr    = arr.sweep_base;
      r_next.remain = arr.sweep_count;
    end else if (r_reg.busy) begin
      r_next.ptr    = r_reg.ptr + 1'b1;
      r_next.remain = r_reg.remain - 1'b1;
      if (r_reg.remain <= 16'h0001) begin
        r_next.busy = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '{init_pend: INIT_BLANK, busy: 1'b0, ptr: '0, remain: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // erase writes ones, program only clears bits
  always_ff @(posedge clk_i) begin
    if (r_reg.busy) begin
      mem[r_reg.ptr] <= ERASED; // [RULE1]
    end else if (arr.wr_en) begin
      mem[arr.wr_addr] <= mem[arr.wr_addr] & arr.wr_data; // [RULE1]
    end
  end

  // read ports
  assign arr.rd_data   = mem[arr.rd_addr];
  assign arr.prot_byte = mem[PROT_IDX[ARRAY_AW-1:0]];
  assign arr.busy      = r_reg.busy | r_reg.init_pend;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sweep_takes_start: assert property (arr.sweep_start && !arr.busy |=> r_reg.busy)
    else $error("sweep start not taken");
  a_erase_reads_ones: assert property (r_reg.busy |=> mem[$past(r_reg.ptr)] == ERASED) // [RULE1]
    else $error("erased cell not all ones");

endmodule // flash_cell_array

/* File: dv/testbench.sv */
// testbench: self-checking bench of the flash erase and protect controller
// assumes INIT_BLANK=1, so every reset leaves the whole array erased
`timescale 1ns/1ps
module testbench;
  import flash_ctrl_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        pump;
  logic        busy;
  logic [15:0] adr;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic [31:0] rd;
  logic [3:0]  lanes;
  int          err_count;
  int          cmp_count;
  int          cycles;

  // ==========================================================
  // device under test, byte lanes driven per access
  flash_array_erase_protect_ctrl #(.INIT_BLANK(1'b1)) uut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(lanes), .WB_DAT_I(dat_w),
    .WB_DAT_O(dat_r), .WB_ACK_O(ack), .PUMP_ON_O(pump), .ARRAY_BUSY_O(busy));

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // cut a hang short at a 100000-cycle ceiling, only a little above the full run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // bus and compare helpers
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'h1);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    lanes <= s;
    adr   <= a;
    dat_w <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string msg);
    wb(1'b0, a, 8'h00);
    chk(rd[7:0], exp, msg);
    chk(rd[31:24] | rd[23:16] | rd[15:8], 8'h00, "upper read bits");
  endtask

  // select, read protect byte, latch address, wait setup, raise high voltage
  task automatic arm(input logic [7:0] sel, input logic [15:0] a, input logic ok);
    wb(1'b1, CTRL_IDX, sel);
    wb(1'b0, PROT_IDX, 8'h00);
    wb(1'b1, a, 8'hFF);
    repeat (SETUP_CYC) @(posedge clk);
    wb(1'b1, CTRL_IDX, sel | 8'h08);
    rdchk(CTRL_IDX, ok ? (sel | 8'h08) : sel, "high voltage grant");
    chk({7'h00, pump}, {7'h00, ok}, "pump follows grant");
    while (busy !== 1'b0) @(posedge clk);
  endtask

  // drop selects, then high voltage, then clear the sticky refusal
  task automatic disarm();
    wb(1'b1, CTRL_IDX, 8'h08);
    wb(1'b1, CTRL_IDX, 8'h00);
    chk({7'h00, pump}, 8'h00, "pump off");
    wb(1'b1, STAT_IDX, 8'h01);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    arm(8'h01, a, 1'b1);
    wb(1'b1, a, d);
    disarm();
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({7'h00, busy}, 8'h01, "array blanking after reset");
    rdchk(CTRL_IDX, CTRL_RESET, "ctrl after reset");
    chk({7'h00, pump}, 8'h00, "pump after reset");
    while (busy !== 1'b0) @(posedge clk);
    rdchk(STAT_IDX, 8'h00, "status idle after blanking");
  endtask

  // ==========================================================
  // scenarios
  // blank reads, read-only protect byte, interlock, early high voltage
  task automatic t_basic();
    rdchk(16'h8000, ERASED, "blank cell");
    rdchk(16'h7FFF, 8'h00, "unmapped read");
    wb(1'b1, PROT_IDX, 8'h00);
    rdchk(PROT_IDX, PROT_NONE, "protect byte plain write");
    wb(1'b1, CTRL_IDX, 8'h03);
    rdchk(CTRL_IDX, 8'h00, "erase and program together");
    wb(1'b1, CTRL_IDX, 8'h02, 4'h0);
    rdchk(CTRL_IDX, 8'h00, "write with lane 0 off");
    wb(1'b1, CTRL_IDX, 8'h02);
    wb(1'b1, CTRL_IDX, 8'h0A);
    rdchk(CTRL_IDX, 8'h02, "high voltage without sequence");
    rdchk(STAT_IDX, 8'h01, "refusal flagged");
    disarm();
  endtask

  // three rows programmed, a write outside the latched row ignored
  task automatic t_program();
    arm(8'h01, 16'h8000, 1'b1);
    wb(1'b1, 16'h8000, 8'h5A);
    wb(1'b1, 16'h8040, 8'h00);
    disarm();
    rdchk(16'h8000, 8'h5A, "programmed byte");
    rdchk(16'h8040, ERASED, "other row untouched");
    prog(16'h8100, 8'hA5);
    prog(16'hFF81, 8'h11);
    rdchk(16'hFF81, 8'h11, "second protect byte programmed");
  endtask

  // erasing the unprotected vector page wipes protect bytes only there
  task automatic t_vector();
    arm(8'h02, 16'hFF82, 1'b1);
    disarm();
    rdchk(16'hFF81, ERASED, "protect byte erased with vectors");
    rdchk(16'h8000, 8'h5A, "other page kept");
  endtask

  // protect start 8100: boundary, refusal, mass erase spares region
  task automatic t_protect();
    prog(PROT_IDX, 8'h02);
    rdchk(PROT_IDX, 8'h02, "protect byte programmed");
    arm(8'h02, 16'h8100, 1'b0);
    rdchk(STAT_IDX, 8'h05, "latched address protected");
    disarm();
    rdchk(16'h8100, 8'hA5, "protected byte kept");
    arm(8'h02, 16'h80FF, 1'b1);
    disarm();
    arm(8'h06, 16'h8000, 1'b1);
    disarm();
    rdchk(16'h8000, ERASED, "mass erased");
    rdchk(16'h8100, 8'hA5, "mass erase spares region");
  endtask

  // all-zero protect byte locks erase and program at the array base 8000
  task automatic t_lock_all();
    prog(PROT_IDX, 8'h00);
    arm(8'h02, 16'h8000, 1'b0);
    disarm();
    arm(8'h01, 16'h8000, 1'b0);
    disarm();
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n     = 1'b0;
    cyc       = 1'b0;
    stb       = 1'b0;
    we        = 1'b0;
    adr       = 16'h0000;
    dat_w     = 32'h00000000;
    lanes     = 4'h0;
    err_count = 0;
    cmp_count = 0;
    cycles    = 0;
    do_reset();
    t_basic();
    t_program();
    t_vector();
    t_protect();
    do_reset();
    t_lock_all();
    report_and_stop();
  end
endmodule // testbench
